//--- pkg/mcr_pkg.sv
// Purpose: Shared constants and types of the master clock and routing block.
// Assumes: A 250 MHz bus clock; register offsets are byte addresses.
// Notes: Rates are kept in units of 100 Hz.
package mcr_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_NS = 4;
   localparam int WIN_MS = 10;
   localparam int WIN_CYC = WIN_MS * 1_000_000 / CLK_NS;
   localparam logic [3:0] MUTE_N = 4'h8;

   // ==========================================================
   // Rates
   localparam int RATE_W = 12;
   localparam logic [11:0] RATE_MIN = 12'h136;
   localparam logic [11:0] RATE_MAX = 12'h3d4;
   localparam logic [11:0] RATE_SAT = 12'hfff;
   localparam logic [4:0] WLEN_MIN = 5'h08;
   localparam logic [4:0] WLEN_MAX = 5'h18;
   typedef enum logic [2:0] {R32K, R44K1, R48K, R88K2, R96K} mcr_rate_t;
   typedef enum logic [1:0] {SRC_INT, SRC_SPDIF, SRC_LP, SRC_WC} mcr_src_t;
   typedef enum logic [1:0] {EXT_SPDIF, EXT_OPT, EXT_WC} mcr_ext_t;
   typedef enum logic [1:0] {FEED_HOST, FEED_MIX, FEED_ANA_IN, FEED_DIG_IN} mcr_feed_t;

   // ==========================================================
   // Register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_ROUTE = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_SAVE = 8'h0c;
   localparam logic [31:0] CTRL_RST = 32'h0000c020;
   localparam logic [31:0] CTRL_MASK = 32'h0001ff77;
   localparam logic [31:0] ROUTE_RST = 32'h00000000;
   localparam logic [31:0] ROUTE_MASK = 32'h0001ffff;

   typedef struct packed {
      logic [14:0] rsvd0;
      logic sa_48k;
      logic [4:0] wlen;
      logic spdif_wclk;
      logic non_audio;
      logic out_lp;
      logic rsvd1;
      logic [2:0] int_rate;
      logic rsvd2;
      logic [1:0] ext_src;
      logic ext_mode;
   } mcr_ctrl_t;

   typedef struct packed {
      logic [14:0] rsvd;
      logic mix_spdif;
      logic [7:0] mix_lp;
      logic [7:0] mix_ana;
   } mcr_route_t;

   typedef struct packed {
      logic [11:0] rate;
      logic [9:0] rsvd;
      logic [1:0] act_src;
      logic fw_lp;
      logic standalone;
      logic muted;
      logic wc_present;
      logic no_signal;
      logic locked;
      logic lp_present;
      logic spdif_present;
   } mcr_stat_t;

   // ==========================================================
   // Phase increment of the internal sample clock generator.
   function automatic logic [31:0] nco_inc(input logic [2:0] r);
      logic [63:0] hz;
      hz = 64'h0000bb80;
      case (r)
         R32K: hz = 64'h00007d00;
         R44K1: hz = 64'h0000ac44;
         R88K2: hz = 64'h00015888;
         R96K: hz = 64'h00017700;
         default: hz = 64'h0000bb80;
      endcase
      return 32'((hz << 32) / 64'(CLK_HZ));
   endfunction
endpackage

//--- logic/mcr_rate_meter.sv
// Purpose: Measures the frame rate of one incoming reference.
// Assumes: tick pulses one cycle per received sample frame.
// Notes: Rate is the tick count over one gate window.
`timescale 1ns/1ns
module mcr_rate_meter #(
   parameter int WIN_CYC = mcr_pkg::WIN_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   output logic [11:0] rate,
   output logic valid
);
   localparam int CW = $clog2(WIN_CYC + 1);

   typedef struct packed {
      logic [CW-1:0] win;
      logic [11:0] cnt;
      logic [11:0] rate;
      logic valid;
   } mcr_meter_st_t;

   mcr_meter_st_t s_r;
   mcr_meter_st_t s_nxt;

   // ==========================================================
   // Gate window counter
   always_comb begin
      s_nxt = s_r;
      if (s_r.cnt != mcr_pkg::RATE_SAT && tick) begin
         s_nxt.cnt = s_r.cnt + 12'h001;
      end
      s_nxt.win = s_r.win + CW'(1);
      if (s_r.win == CW'(WIN_CYC - 1)) begin
         s_nxt.win = '0;
         s_nxt.cnt = 12'h000;
         s_nxt.rate = s_r.cnt;
         s_nxt.valid = s_r.cnt >= mcr_pkg::RATE_MIN && s_r.cnt <= mcr_pkg::RATE_MAX;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rate = s_r.rate;
   assign valid = s_r.valid;
endmodule

//--- logic/mcr_top.sv
// Purpose: Sample clock selection, rate display, output format and stand-alone routing.
// Assumes: Reference ticks, straps and stored settings are synchronous to hclk.
// Notes: Registers sit on an AHB-Lite slave; reads take one wait state.
// Behaviour
// [RL1] Internal mode generates the sample clock, 32 to 96 kHz, driven out.
// [RL2] Lightpipe firmware caps every selectable rate at 48 kHz.
// [RL3] External mode takes S/PDIF, lightpipe or word clock as reference.
// [RL4] The measured rate of the selected reference is shown when usable.
// [RL5] Separate presence flags for S/PDIF and lightpipe while valid.
// [RL6] Word clock indicator lit while word clock is the reference.
// [RL7] Optical reference locks to whichever framing, S/PDIF or lightpipe, arrives.
// [RL8] Absent or lost reference reports no signal instead of a rate.
// [RL9] Other streams must be locked to the same word clock.
// [RL10] Lightpipe firmware selects lightpipe or S/PDIF output; otherwise S/PDIF only.
// [RL11] S/PDIF receiver may be clocked from the word clock input.
// [RL12] Sample words of 8 to 24 bits are carried.
// [RL13] Non-audio setting passes compressed bitstreams on the S/PDIF output.
// [RL14] Power-up without host enters stand-alone and restores stored settings.
// [RL15] Stand-alone, other firmware: inputs 7 and 8 feed unassigned S/PDIF output.
// [RL16] Stand-alone, other firmware: S/PDIF input feeds unassigned outputs 1/2.
// [RL17] Stand-alone, lightpipe firmware: analog inputs 1-8 feed lightpipe outputs 1-8.
// [RL18] Stand-alone, lightpipe firmware: lightpipe inputs 1-8 feed analog outputs.
// [RL19] Stand-alone, lightpipe firmware: mixer assignment overrides default routing.
// [RL20] Stand-alone slaves to a valid external clock, word clock first.
// [RL21] Stand-alone master selects 44.1 kHz or 48 kHz.
// [RL22] One selected clock drives all ports; source changes mute the ports briefly.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module mcr_top #(
   parameter int WIN_CYC = mcr_pkg::WIN_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic spdif_tick,
   input wire logic lp_tick,
   input wire logic wc_tick,
   input wire logic fw_lightpipe,
   input wire logic host_present,
   input wire logic [31:0] nv_ctrl_in,
   input wire logic [31:0] nv_route_in,
   output logic fs_tick,
   output logic wclk_out,
   output logic wc_led,
   output logic spdif_lamp,
   output logic lp_lamp,
   output logic [1:0] clk_src,
   output logic spdif_rx_wclk,
   output logic dout_lp,
   output logic non_audio,
   output logic [4:0] wlen,
   output logic port_mute,
   output logic [15:0] ana_feed,
   output logic [15:0] lp_feed,
   output logic [1:0] spdif_feed,
   output logic standalone,
   output logic nv_wr,
   output logic [31:0] nv_ctrl_out,
   output logic [31:0] nv_route_out
);
   typedef struct packed {
      logic hrdy;
      logic [31:0] hrdata;
      logic ap_valid;
      logic ap_write;
      logic [7:0] ap_addr;
      mcr_pkg::mcr_ctrl_t ctrl;
      mcr_pkg::mcr_route_t route;
      logic init;
      logic fw_lp;
      logic sa;
      logic [1:0] act;
      logic [3:0] mute_cnt;
      logic [31:0] nco;
      logic fs_tick;
      logic wclk;
      logic wc_led;
      logic spdif_lamp;
      logic lp_lamp;
      logic rx_wclk;
      logic dout_lp;
      logic non_audio;
      logic [4:0] wlen;
      logic mute;
      logic [15:0] ana_feed;
      logic [15:0] lp_feed;
      logic [1:0] spdif_feed;
      logic nv_wr;
      logic [11:0] rate;
      logic no_signal;
      logic locked;
   } mcr_state_t;

   mcr_state_t s_r;
   mcr_state_t s_nxt;
   logic [2:0] ticks;
   logic [2:0] mvalid;
   logic [11:0] mrate [3];

   // ==========================================================
   // Rate meters: 0 S/PDIF, 1 lightpipe, 2 word clock
   assign ticks = {wc_tick, lp_tick, spdif_tick};

   for (genvar g = 0; g < 3; g++) begin : g_meter
      mcr_rate_meter #(
         .WIN_CYC(WIN_CYC)
      ) u_meter (
         .hclk(hclk),
         .hresetn(hresetn),
         .tick(ticks[g]),
         .rate(mrate[g]),
         .valid(mvalid[g])
      );
   end

   // ==========================================================
   // Register read data
   function automatic logic [31:0] rd_word(input mcr_state_t s, input logic [7:0] a);
      mcr_pkg::mcr_stat_t st;
      st = '0;
      st.rate = s.rate;
      st.act_src = s.act;
      st.fw_lp = s.fw_lp;
      st.standalone = s.sa;
      st.muted = s.mute;
      st.wc_present = mvalid[2];
      st.no_signal = s.no_signal;
      st.locked = s.locked;
      st.lp_present = s.lp_lamp;
      st.spdif_present = s.spdif_lamp;
      case (a)
         mcr_pkg::A_CTRL: return s.ctrl;
         mcr_pkg::A_ROUTE: return s.route;
         mcr_pkg::A_STAT: return st;
         default: return 32'h00000000;
      endcase
   endfunction

   // ==========================================================
   // Next state
   always_comb begin
      logic [2:0] rsel;
      logic [1:0] act;
      logic [32:0] acc;
      logic ext_ok;
      logic [4:0] wl;
      rsel = mcr_pkg::R48K;
      act = mcr_pkg::SRC_INT;
      acc = 33'h000000000;
      ext_ok = 1'b0;
      wl = 5'h00;
      s_nxt = s_r;
      s_nxt.nv_wr = 1'b0;

      // Bus data phase: writes land here, reads load data after one wait.
      if (s_r.ap_valid && s_r.ap_write && s_r.hrdy) begin
         unique case (s_r.ap_addr)
            mcr_pkg::A_CTRL: begin
               s_nxt.ctrl = hwdata & mcr_pkg::CTRL_MASK;
               wl = hwdata[15:11];
               if (wl < mcr_pkg::WLEN_MIN) begin
                  s_nxt.ctrl.wlen = mcr_pkg::WLEN_MIN; // [RL12]
               end else if (wl > mcr_pkg::WLEN_MAX) begin
                  s_nxt.ctrl.wlen = mcr_pkg::WLEN_MAX; // [RL12]
               end
            end
            mcr_pkg::A_ROUTE: s_nxt.route = hwdata & mcr_pkg::ROUTE_MASK;
            mcr_pkg::A_SAVE: s_nxt.nv_wr = 1'b1;
            default: ;
         endcase
      end
      if (s_r.ap_valid && !s_r.hrdy) begin
         s_nxt.hrdata = rd_word(s_r, s_r.ap_addr);
         s_nxt.hrdy = 1'b1;
         s_nxt.ap_valid = 1'b0;
      end else if (hready) begin
         s_nxt.ap_valid = hsel && htrans[1];
         s_nxt.ap_write = hwrite;
         s_nxt.ap_addr = haddr[mcr_pkg::ADDR_W-1:0];
         s_nxt.hrdy = !(hsel && htrans[1] && !hwrite);
      end

      // Straps are caught once after reset release; stored settings only when no host is present.
      if (!s_r.init) begin
         s_nxt.init = 1'b1;
         s_nxt.fw_lp = fw_lightpipe;
         s_nxt.sa = !host_present;
         if (!host_present) begin
            s_nxt.ctrl = nv_ctrl_in & mcr_pkg::CTRL_MASK; // [RL14]
            s_nxt.route = nv_route_in & mcr_pkg::ROUTE_MASK; // [RL14]
         end
      end

      // Internal rate choice.
      if (s_r.sa) begin
         rsel = s_r.ctrl.sa_48k ? mcr_pkg::R48K : mcr_pkg::R44K1; // [RL21]
      end else if (s_r.ctrl.int_rate <= mcr_pkg::R96K) begin
         rsel = s_r.ctrl.int_rate; // [RL1]
      end
      if (s_r.fw_lp && rsel > mcr_pkg::R48K) begin
         rsel = mcr_pkg::R48K; // [RL2]
      end

      // Reference selection.
      if (s_r.sa) begin
         if (mvalid[2]) begin
            act = mcr_pkg::SRC_WC; // [RL20]
         end else if (mvalid[1]) begin
            act = mcr_pkg::SRC_LP; // [RL20]
         end else if (mvalid[0]) begin
            act = mcr_pkg::SRC_SPDIF; // [RL20]
         end
      end else if (s_r.ctrl.ext_mode) begin
         case (s_r.ctrl.ext_src)
            mcr_pkg::EXT_OPT: begin
               act = mvalid[1] ? mcr_pkg::SRC_LP : mcr_pkg::SRC_SPDIF; // [RL7]
            end
            mcr_pkg::EXT_WC: act = mcr_pkg::SRC_WC; // [RL3]
            default: act = mcr_pkg::SRC_SPDIF; // [RL3]
         endcase
      end
      s_nxt.act = act;

      // Rate display and presence flags.
      unique case (s_r.act)
         mcr_pkg::SRC_SPDIF: ext_ok = mvalid[0];
         mcr_pkg::SRC_LP: ext_ok = mvalid[1];
         mcr_pkg::SRC_WC: ext_ok = mvalid[2];
         mcr_pkg::SRC_INT: ext_ok = 1'b0;
      endcase
      s_nxt.locked = ext_ok;
      s_nxt.no_signal = s_r.act != mcr_pkg::SRC_INT && !ext_ok; // [RL8]
      s_nxt.rate = 12'h000; // [RL8]
      if (ext_ok) begin
         s_nxt.rate = mrate[s_r.act - 2'h1]; // [RL4]
      end
      s_nxt.spdif_lamp = mvalid[0]; // [RL5]
      s_nxt.lp_lamp = mvalid[1]; // [RL5]
      s_nxt.wc_led = act == mcr_pkg::SRC_WC; // [RL6]

      // Sample clock: generator or selected reference, one tick for all ports.
      acc = {1'b0, s_r.nco} + {1'b0, mcr_pkg::nco_inc(rsel)};
      s_nxt.nco = acc[31:0];
      s_nxt.wclk = s_r.act == mcr_pkg::SRC_INT && s_r.nco[31]; // [RL1]
      unique case (s_r.act)
         mcr_pkg::SRC_SPDIF: s_nxt.fs_tick = spdif_tick; // [RL22]
         mcr_pkg::SRC_LP: s_nxt.fs_tick = lp_tick; // [RL22]
         mcr_pkg::SRC_WC: s_nxt.fs_tick = wc_tick; // [RL22]
         mcr_pkg::SRC_INT: s_nxt.fs_tick = acc[32]; // [RL1]
      endcase
      if (act != s_r.act) begin
         s_nxt.mute_cnt = mcr_pkg::MUTE_N; // [RL22]
      end else if (s_r.mute_cnt != 4'h0 && s_r.fs_tick) begin
         s_nxt.mute_cnt = s_r.mute_cnt - 4'h1;
      end
      s_nxt.mute = s_nxt.mute_cnt != 4'h0 || s_nxt.no_signal; // [RL22]

      // Digital port format.
      s_nxt.rx_wclk = s_r.ctrl.spdif_wclk; // [RL11]
      s_nxt.dout_lp = s_r.fw_lp && s_r.ctrl.out_lp; // [RL10]
      s_nxt.non_audio = s_r.ctrl.non_audio && !s_nxt.dout_lp; // [RL13]
      s_nxt.wlen = s_r.ctrl.wlen; // [RL12]

      // Output routing.
      s_nxt.spdif_feed = s_r.route.mix_spdif ? mcr_pkg::FEED_MIX : mcr_pkg::FEED_HOST;
      if (s_r.sa && !s_r.fw_lp && !s_r.route.mix_spdif) begin
         s_nxt.spdif_feed = mcr_pkg::FEED_ANA_IN; // [RL15]
      end
      for (int i = 0; i < 8; i++) begin
         s_nxt.ana_feed[2*i +: 2] = mcr_pkg::FEED_HOST;
         s_nxt.lp_feed[2*i +: 2] = mcr_pkg::FEED_HOST;
         if (s_r.route.mix_ana[i]) begin
            s_nxt.ana_feed[2*i +: 2] = mcr_pkg::FEED_MIX; // [RL19]
         end else if (s_r.sa && (s_r.fw_lp || i < 2)) begin
            s_nxt.ana_feed[2*i +: 2] = mcr_pkg::FEED_DIG_IN; // [RL16] [RL18]
         end
         if (s_r.route.mix_lp[i]) begin
            s_nxt.lp_feed[2*i +: 2] = mcr_pkg::FEED_MIX; // [RL19]
         end else if (s_r.sa && s_r.fw_lp) begin
            s_nxt.lp_feed[2*i +: 2] = mcr_pkg::FEED_ANA_IN; // [RL17]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.hrdy <= 1'b1;
         s_r.ctrl <= mcr_pkg::CTRL_RST;
         s_r.route <= mcr_pkg::ROUTE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign hreadyout = s_r.hrdy;
   assign hrdata = s_r.hrdata;
   assign hresp = 1'b0;
   assign fs_tick = s_r.fs_tick;
   assign wclk_out = s_r.wclk;
   assign wc_led = s_r.wc_led;
   assign spdif_lamp = s_r.spdif_lamp;
   assign lp_lamp = s_r.lp_lamp;
   assign clk_src = s_r.act;
   assign spdif_rx_wclk = s_r.rx_wclk;
   assign dout_lp = s_r.dout_lp;
   assign non_audio = s_r.non_audio;
   assign wlen = s_r.wlen;
   assign port_mute = s_r.mute;
   assign ana_feed = s_r.ana_feed;
   assign lp_feed = s_r.lp_feed;
   assign spdif_feed = s_r.spdif_feed;
   assign standalone = s_r.sa;
   assign nv_wr = s_r.nv_wr;
   assign nv_ctrl_out = s_r.ctrl;
   assign nv_route_out = s_r.route;
endmodule

//--- tb/mcr_top_asserts.sv
// Purpose: Port checks of the clock and routing block.
// Assumes: Straps change only while reset is held.
// Notes: Bound to mcr_top from the bench.
`timescale 1ns/1ns
module mcr_top_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [1:0] clk_src,
   input wire logic wc_led,
   input wire logic wclk_out,
   input wire logic dout_lp,
   input wire logic non_audio,
   input wire logic [4:0] wlen,
   input wire logic port_mute,
   input wire logic nv_wr,
   input wire logic standalone,
   input wire logic host_present,
   input wire logic fw_lightpipe
);
   // ==========================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic tk = hsel && htrans[1] && hready;
   a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (tk && hwrite |=> hreadyout)
      else $error("write stalled");
   a_wc_led: assert property (wc_led == (clk_src == 2'h3))
      else $error("word clock lamp wrong");
   a_wclk_ext: assert property (clk_src != 2'h0 && $past(clk_src) != 2'h0 |-> !wclk_out)
      else $error("clock driven in external mode");
   a_na_only: assert property (non_audio |-> !dout_lp)
      else $error("non audio on lightpipe");
   a_dout_fw: assert property (dout_lp |-> fw_lightpipe)
      else $error("lightpipe out without firmware");
   a_wlen_range: assert property (wlen != 5'h00 |-> wlen >= 5'h08 && wlen <= 5'h18)
      else $error("word length out of range");
   a_mute_change: assert property (clk_src != $past(clk_src) |-> ##[0:2] port_mute)
      else $error("source change not muted");
   a_nv_save: assert property (tk && hwrite && haddr[7:0] == 8'h0c |-> ##[1:3] nv_wr)
      else $error("save not pulsed");
   a_nv_pulse: assert property (nv_wr |=> !nv_wr)
      else $error("save pulse too long");
   a_sa_host: assert property (standalone |-> !host_present)
      else $error("stand-alone with host");
endmodule

//--- tb/mcr_ref_src.sv
// Purpose: Far-side digital audio sources.
// Assumes: One frame every two bus clocks.
// Notes: en bit 0 S/PDIF, bit 1 lightpipe, bit 2 word clock.
`timescale 1ns/1ns
module mcr_ref_src (
   input wire logic hclk,
   input wire logic [2:0] en,
   output logic spdif_tick = 1'b0,
   output logic lp_tick = 1'b0,
   output logic wc_tick = 1'b0
);
   logic ph = 1'b0;
   // One shared frame pace keeps every stream locked to the word clock.
   always @(posedge hclk) begin
      ph <= ~ph;
      spdif_tick <= en[0] & ph;
      lp_tick <= en[1] & ph;
      wc_tick <= en[2] & ph;
   end
endmodule

//--- tb/mcr_top_bench.sv
// Purpose: Self-checking bench of the clock and routing block.
// Assumes: Meter window shortened to 1000 cycles.
// Notes: Four resets cover both firmware kinds and stand-alone.
`timescale 1ns/1ns
module mcr_top_bench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fw = 1'b0, host = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, nvc = 32'h0, nvr = 32'h0, q;
   logic [1:0] htrans = 2'h0;
   logic [2:0] en = 3'h0;
   logic hreadyout, hresp, spdif_tick, lp_tick, wc_tick, fs_tick, wclk_out, wc_led;
   logic spdif_lamp, lp_lamp, spdif_rx_wclk, dout_lp, non_audio, port_mute, standalone, nv_wr;
   logic [1:0] clk_src, spdif_feed;
   logic [4:0] wlen;
   logic [15:0] ana_feed, lp_feed;
   logic [31:0] hrdata, nv_ctrl_out;
   int n_fail = 0, tests_run = 0, cnt;
   always #2 hclk = ~hclk;
   mcr_ref_src u_mcr_ref_src (.hclk(hclk), .en(en), .spdif_tick(spdif_tick),
      .lp_tick(lp_tick), .wc_tick(wc_tick));
   mcr_top #(.WIN_CYC(1000)) u_mcr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .spdif_tick(spdif_tick), .lp_tick(lp_tick), .wc_tick(wc_tick), .fw_lightpipe(fw),
      .host_present(host), .nv_ctrl_in(nvc), .nv_route_in(nvr), .fs_tick(fs_tick),
      .wclk_out(wclk_out), .wc_led(wc_led), .spdif_lamp(spdif_lamp), .lp_lamp(lp_lamp),
      .clk_src(clk_src), .spdif_rx_wclk(spdif_rx_wclk), .dout_lp(dout_lp),
      .non_audio(non_audio), .wlen(wlen), .port_mute(port_mute), .ana_feed(ana_feed),
      .lp_feed(lp_feed), .spdif_feed(spdif_feed), .standalone(standalone), .nv_wr(nv_wr),
      .nv_ctrl_out(nv_ctrl_out), .nv_route_out());
   // ==========================================================
   // Tasks
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic hs();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         n_fail++;
         results();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hs();
      htrans <= 2'h0;
      hwdata <= d;
      hs();
      q = hrdata;
   endtask
   task automatic rst(input logic f, input logic h, input logic [31:0] c,
      input logic [31:0] r);
      hresetn <= 1'b0;
      fw <= f;
      host <= h;
      nvc <= c;
      nvr <= r;
      en <= 3'h0;
      wt(8);
      hresetn <= 1'b1;
      wt(3);
   endtask
   task automatic fsn();
      cnt = 0;
      repeat (20000) begin
         @(posedge hclk);
         if (fs_tick === 1'b1) cnt++;
      end
   endtask
   task automatic ext(input logic [2:0] e, input logic [31:0] c);
      en <= e;
      bus(1'b1, 8'h00, c);
      wt(4000);
      bus(1'b0, 8'h08, 32'h0);
   endtask
   // ==========================================================
   // Scenarios
   initial begin
      rst(1'b0, 1'b1, 32'h0, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0000c020);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, 8'h00, 32'h00001340);
      wt(2);
      chk({25'h0, wlen, dout_lp, non_audio}, 32'h21);
      fsn();
      chk({29'h0, clk_src, cnt >= 7 && cnt <= 8}, 32'h1);
      bus(1'b1, 8'h00, 32'h0000f800);
      wt(2);
      chk({27'h0, wlen}, 32'h18);
      ext(3'b001, 32'h1);
      chk({28'h0, spdif_lamp, lp_lamp, clk_src}, 32'h9);
      chk({19'h0, q[31:20], q[3]}, 32'h3e8);
      ext(3'b101, 32'h405);
      chk({28'h0, spdif_rx_wclk, wc_led, clk_src}, 32'hf);
      ext(3'b010, 32'h3);
      chk({29'h0, lp_lamp, clk_src}, 32'h6);
      ext(3'b001, 32'h3);
      chk({30'h0, clk_src}, 32'h1);
      ext(3'b000, 32'h3);
      chk({18'h0, port_mute, q[31:20], q[3]}, 32'h2001);
      bus(1'b1, 8'h0c, 32'h0);
      wt(1);
      chk({31'h0, nv_wr}, 32'h1);
      wt(1);
      chk(nv_ctrl_out, 32'h00004003);
      rst(1'b1, 1'b1, 32'h0, 32'h0);
      bus(1'b1, 8'h00, 32'h00000140);
      fsn();
      chk({30'h0, dout_lp, cnt >= 3 && cnt <= 4}, 32'h3);
      rst(1'b1, 1'b0, 32'hffffc120, 32'h00000101);
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h0001c120);
      chk({31'h0, standalone}, 32'h1);
      chk({ana_feed, lp_feed}, 32'hfffdaaa9);
      en <= 3'b110;
      wt(4000);
      chk({30'h0, clk_src}, 32'h3);
      rst(1'b0, 1'b0, 32'h0, 32'h0);
      chk({14'h0, spdif_feed, ana_feed}, 32'h2000f);
      results();
   end
endmodule
bind mcr_top mcr_top_asserts u_mcr_top_asserts (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .clk_src(clk_src), .wc_led(wc_led), .wclk_out(wclk_out),
   .dout_lp(dout_lp), .non_audio(non_audio), .wlen(wlen), .port_mute(port_mute),
   .nv_wr(nv_wr), .standalone(standalone), .host_present(host_present),
   .fw_lightpipe(fw_lightpipe));
